// ===== core/ttr_core.sv
// turn-on sequencer: delay, ramp, turn-on timeout and retry engine,
// with the configuration registers reached by command code.
// assumes command strobes and measured input come from logic on CLK_IN;
// START_IN and VOUT_GOOD_IN are pins and are synchronised here.
`timescale 1ns/1ns
module ttr_core #(
  parameter int TICK_CYC = ttr_pkg::TICK_CYC
) (
  // clock and reset
  input  wire logic        CLK_IN,
  input  wire logic        RSTN_IN,
  // sequencing pins and measurement
  input  wire logic        START_IN,
  input  wire logic        VOUT_GOOD_IN,
  input  wire logic [15:0] VIN_MEAS_IN,
  input  wire logic        CLR_FAULT_IN,
  // command port
  input  wire logic        CMD_WR_IN,
  input  wire logic [7:0]  CMD_CODE_IN,
  input  wire logic [15:0] CMD_DATA_IN,
  input  wire logic [7:0]  CMD_RD_CODE_IN,
  output logic      [15:0] RD_DATA_OUT,
  // power stage and status
  output logic             OUT_EN_OUT,
  output logic             RAMP_OUT,
  output logic             ALERT_N_OUT,
  output logic             TON_FAULT_OUT,
  output logic             UV_WARN_OUT
);
  ttr_pkg::ttr_cfg_t   cfg;
  ttr_pkg::ttr_cfg_t   next_cfg;
  ttr_pkg::ttr_state_t state;
  ttr_pkg::ttr_state_t next_state;

  logic [1:0]  start_sy;
  logic [1:0]  good_sy;
  logic        start;
  logic        good;
  logic [15:0] q_cnt;
  logic [15:0] next_q_cnt;
  logic [2:0]  sd_cnt;
  logic [2:0]  next_sd_cnt;
  logic        pend;
  logic        next_pend;
  logic [2:0]  rcnt;
  logic [2:0]  next_rcnt;
  logic        ton_flt;
  logic        next_ton_flt;
  logic        uv_flt;
  logic        next_uv_flt;
  logic        hit;
  logic        next_hit;
  logic [15:0] rd;
  logic [15:0] next_rd;
  logic        tick;
  logic        tmo;
  logic        fail;
  logic [15:0] dly_q;
  logic [15:0] rise_q;
  logic [15:0] lim_q;
  logic [15:0] hic_q;
  logic [1:0]  mode;
  logic [2:0]  rtry;
  logic [2:0]  tcode;

  // shutdown delay in switching-clock periods
  function automatic logic [2:0] sd_cycles(input logic [2:0] c);
    if (c >= 3'h5) return 3'h7;
    if (c >= 3'h2) return 3'h3;
    return 3'h1;
  endfunction : sd_cycles

  // pins pass two flops before use
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      start_sy <= 2'h0;
      good_sy  <= 2'h0;
    end else begin
      start_sy <= {start_sy[0], START_IN};
      good_sy  <= {good_sy[0], VOUT_GOOD_IN};
    end
  end
  assign start = start_sy[1];
  assign good  = good_sy[1];

  // register file
  always_comb begin
    next_cfg = cfg;
    if (CMD_WR_IN) begin
      unique case (CMD_CODE_IN)
        ttr_pkg::CMD_VIN_UV:  next_cfg.vin_uv  = CMD_DATA_IN;
        ttr_pkg::CMD_TON_DLY: next_cfg.ton_dly = CMD_DATA_IN;
        ttr_pkg::CMD_TON_RSE: next_cfg.ton_rse = CMD_DATA_IN;
        ttr_pkg::CMD_TON_LIM: next_cfg.ton_lim = CMD_DATA_IN;
        ttr_pkg::CMD_TON_RSP: next_cfg.ton_rsp = CMD_DATA_IN[7:0];
        default: next_cfg = cfg;
      endcase
    end
    unique case (CMD_RD_CODE_IN)
      ttr_pkg::CMD_VIN_UV:  next_rd = cfg.vin_uv;
      ttr_pkg::CMD_TON_DLY: next_rd = cfg.ton_dly;
      ttr_pkg::CMD_TON_RSE: next_rd = cfg.ton_rse;
      ttr_pkg::CMD_TON_LIM: next_rd = cfg.ton_lim;
      ttr_pkg::CMD_TON_RSP: next_rd = {8'h00, cfg.ton_rsp};
      ttr_pkg::CMD_SEQ_STS:
        next_rd = {5'h00, rcnt, pend, state, uv_flt, ton_flt, good, start};
      default: next_rd = 16'h0000;
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      cfg <= '{ttr_pkg::RST_VIN_UV, ttr_pkg::RST_TON_DLY,
               ttr_pkg::RST_TON_RSE, ttr_pkg::RST_TON_LIM,
               ttr_pkg::RST_TON_RSP};
      rd  <= 16'h0000;
    end else begin
      cfg <= next_cfg;
      rd  <= next_rd;
    end
  end
  assign RD_DATA_OUT = rd;

  // decoded timing, all in quarter ms
  always_comb begin
    logic [15:0] r;
    logic [15:0] l;
    r = ttr_pkg::ttr_sat(ttr_pkg::ttr_lin(cfg.ton_rse, ttr_pkg::SH_QMS));
    l = ttr_pkg::ttr_sat(ttr_pkg::ttr_lin(cfg.ton_lim, ttr_pkg::SH_QMS));
    dly_q = ttr_pkg::ttr_sat(ttr_pkg::ttr_lin(cfg.ton_dly, ttr_pkg::SH_QMS));
    if (r < ttr_pkg::RISE_MIN_Q) rise_q = ttr_pkg::RISE_MIN_Q;
    else if (r > ttr_pkg::RISE_MAX_Q) rise_q = ttr_pkg::RISE_MAX_Q;
    else rise_q = r;
    lim_q = (l > ttr_pkg::LIM_MAX_Q) ? ttr_pkg::LIM_MAX_Q : l;
    mode  = cfg.ton_rsp[ttr_pkg::RSP_MODE_HI:ttr_pkg::RSP_MODE_LO];
    rtry  = cfg.ton_rsp[ttr_pkg::RSP_RTRY_HI:ttr_pkg::RSP_RTRY_LO];
    tcode = cfg.ton_rsp[ttr_pkg::RSP_TIME_HI:ttr_pkg::RSP_TIME_LO];
    hic_q = 16'((tcode == 3'h0 ? 16'h1 : {13'h0, tcode}) * rise_q);
  end

  ttr_tick #(.TICK_CYC(TICK_CYC)) u_tick (
    .clk_in     (CLK_IN),
    .rstn_in    (RSTN_IN),
    .restart_in (next_state != state),
    .tick_out   (tick)
  );

  assign tmo = (state == ttr_pkg::S_RAMP) && !hit && !good &&
               (lim_q != 16'h0) && (q_cnt >= lim_q);

  // sequencer
  always_comb begin
    next_state   = state;
    next_q_cnt   = (tick && q_cnt != 16'hffff) ? q_cnt + 16'h1 : q_cnt;
    next_sd_cnt  = sd_cnt;
    next_pend    = pend;
    next_rcnt    = rcnt;
    next_hit     = hit | tmo;
    fail         = 1'b0;
    next_uv_flt  = (uv_flt && !CLR_FAULT_IN) ||
                   (ttr_pkg::ttr_lin(VIN_MEAS_IN, ttr_pkg::SH_VLT) <
                    ttr_pkg::ttr_lin(cfg.vin_uv, ttr_pkg::SH_VLT));
    next_ton_flt = (ton_flt && !CLR_FAULT_IN) || tmo;
    if (tmo) begin
      if (mode == ttr_pkg::MODE_DEFER) begin
        next_pend   = 1'b1;
        next_sd_cnt = sd_cycles(tcode) - 3'h1;
      end else if (mode != ttr_pkg::MODE_IGNORE) begin
        fail = 1'b1;
      end
    end else if (pend) begin
      next_sd_cnt = sd_cnt - 3'h1;
      if (sd_cnt == 3'h0) begin
        next_pend = 1'b0;
        fail = !good;
      end
    end
    unique case (state)
      ttr_pkg::S_IDLE: begin
        if (start) next_state = ttr_pkg::S_DELAY;
      end
      ttr_pkg::S_DELAY: begin
        if (q_cnt >= dly_q) next_state = ttr_pkg::S_RAMP;
      end
      ttr_pkg::S_RAMP: begin
        if (fail) begin
          next_pend = 1'b0;
          if (rtry == ttr_pkg::RTRY_LATCH) next_state = ttr_pkg::S_LATCH;
          else if (rtry == ttr_pkg::RTRY_FOREVR || rcnt < rtry) begin
            next_state = ttr_pkg::S_RESTART_INTERVAL;
            if (rtry != ttr_pkg::RTRY_FOREVR) next_rcnt = rcnt + 3'h1;
          end else next_state = ttr_pkg::S_LATCH;
        end else if (good && q_cnt >= rise_q && !pend) begin
          next_state = ttr_pkg::S_ON;
        end
      end
      ttr_pkg::S_ON: begin
        next_rcnt = 3'h0;
      end
      ttr_pkg::S_RESTART_INTERVAL: begin
        if (q_cnt >= hic_q) next_state = ttr_pkg::S_RAMP;
      end
      ttr_pkg::S_LATCH: begin
        if (CLR_FAULT_IN) next_state = ttr_pkg::S_IDLE;
      end
      default: next_state = ttr_pkg::S_IDLE;
    endcase
    if (!start && state != ttr_pkg::S_LATCH) begin
      next_state = ttr_pkg::S_IDLE;
      next_rcnt  = 3'h0;
      next_pend  = 1'b0;
    end
    if (next_state != state) begin
      next_q_cnt = 16'h0;
      next_hit   = 1'b0;
    end
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      state   <= ttr_pkg::S_IDLE;
      q_cnt   <= 16'h0;
      sd_cnt  <= 3'h0;
      pend    <= 1'b0;
      rcnt    <= 3'h0;
      ton_flt <= 1'b0;
      uv_flt  <= 1'b0;
      hit     <= 1'b0;
    end else begin
      state   <= next_state;
      q_cnt   <= next_q_cnt;
      sd_cnt  <= next_sd_cnt;
      pend    <= next_pend;
      rcnt    <= next_rcnt;
      ton_flt <= next_ton_flt;
      uv_flt  <= next_uv_flt;
      hit     <= next_hit;
    end
  end

  assign OUT_EN_OUT    = (state == ttr_pkg::S_RAMP) ||
                         (state == ttr_pkg::S_ON);
  assign RAMP_OUT      = (state == ttr_pkg::S_RAMP) && (q_cnt < rise_q);
  assign ALERT_N_OUT   = !(ton_flt || uv_flt);
  assign TON_FAULT_OUT = ton_flt;
  assign UV_WARN_OUT   = uv_flt;

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);

  alert_low_a: assert property (ton_flt |-> !ALERT_N_OUT)
    else $error("alert high while timeout fault set");
  ignore_run_a: assert property (tmo && mode == ttr_pkg::MODE_IGNORE && start
    |=> OUT_EN_OUT && ton_flt)
    else $error("ignore response interrupted output");
  zero_limit_a: assert property (lim_q == 16'h0 |-> !tmo)
    else $error("timeout raised with zero limit");
  delay_off_a: assert property (state == ttr_pkg::S_DELAY
    && q_cnt < dly_q && start |=> !OUT_EN_OUT)
    else $error("output on before turn-on delay");
  rise_clamp_a: assert property (rise_q >= ttr_pkg::RISE_MIN_Q)
    else $error("rise time below half a millisecond");
  disable_now_a: assert property (tmo && mode[1] && start
    |=> !OUT_EN_OUT)
    else $error("output kept on after disable response");
  defer_on_a: assert property (tmo && mode == ttr_pkg::MODE_DEFER && start
    |=> OUT_EN_OUT && pend)
    else $error("output dropped during deferred response");
  defer_len_a: assert property (tmo && mode == ttr_pkg::MODE_DEFER
    && tcode >= 3'h5 && start |=> pend[*7] ##1 !pend)
    else $error("deferred delay not seven periods");
  latch_hold_a: assert property (state == ttr_pkg::S_LATCH && !CLR_FAULT_IN
    |=> state == ttr_pkg::S_LATCH)
    else $error("latched off state left without clear");
  retry_cap_a: assert property (rcnt <= 3'h6)
    else $error("restart count past six");
  on_clear_a: assert property (state == ttr_pkg::S_ON && start
    |=> rcnt == 3'h0)
    else $error("restart count kept after good turn-on");
  uv_warn_a: assert property (ttr_pkg::ttr_lin(VIN_MEAS_IN, ttr_pkg::SH_VLT)
    < ttr_pkg::ttr_lin(cfg.vin_uv, ttr_pkg::SH_VLT) |=> !ALERT_N_OUT
    && UV_WARN_OUT)
    else $error("input warning missed");
  restart_interval_wait_a: assert property (state == ttr_pkg::S_RESTART_INTERVAL
    && q_cnt < hic_q && start |=> state == ttr_pkg::S_RESTART_INTERVAL)
    else $error("restart before interval elapsed");

  on_reached_c: cover property (state == ttr_pkg::S_RAMP
    ##1 state == ttr_pkg::S_ON);
  restart_interval_c: cover property (state == ttr_pkg::S_RESTART_INTERVAL
    ##1 state == ttr_pkg::S_RAMP);
  latched_c: cover property (state == ttr_pkg::S_LATCH);
  deferred_c: cover property (pend && sd_cnt == 3'h0);
endmodule : ttr_core

// ===== core/ttr_pkg.sv
// turn-on timing and timeout-retry package: command codes, field layout,
// reset values and timing constants shared by the sequencer files.
// assumes a 50 MHz device clock that is also the switching clock.
package ttr_pkg;
  // command codes of the configuration registers and of the read-only status word
  localparam logic [7:0] CMD_VIN_UV  = 8'h58;
  localparam logic [7:0] CMD_TON_DLY = 8'h60;
  localparam logic [7:0] CMD_TON_RSE = 8'h61;
  localparam logic [7:0] CMD_TON_LIM = 8'h62;
  localparam logic [7:0] CMD_TON_RSP = 8'h63;
  localparam logic [7:0] CMD_SEQ_STS = 8'hd0;
  // reset values
  localparam logic [15:0] RST_VIN_UV  = 16'h0000;
  localparam logic [15:0] RST_TON_DLY = 16'h0000;
  localparam logic [15:0] RST_TON_RSE = 16'h0000;
  localparam logic [15:0] RST_TON_LIM = 16'h0000;
  localparam logic [7:0]  RST_TON_RSP = 8'h00;
  // response byte fields
  localparam int RSP_MODE_HI = 7;
  localparam int RSP_MODE_LO = 6;
  localparam int RSP_RTRY_HI = 5;
  localparam int RSP_RTRY_LO = 3;
  localparam int RSP_TIME_HI = 2;
  localparam int RSP_TIME_LO = 0;
  localparam logic [1:0] MODE_IGNORE = 2'h0;
  localparam logic [1:0] MODE_DEFER  = 2'h1;
  localparam logic [2:0] RTRY_LATCH  = 3'h0;
  localparam logic [2:0] RTRY_FOREVR = 3'h7;
  // timing: every ms timer steps in quarter milliseconds
  localparam int CLK_NS     = 20;
  localparam int QUARTER_NS = 250000;
  localparam int TICK_CYC   = QUARTER_NS / CLK_NS;
  localparam logic [15:0] RISE_MIN_Q = 16'h0002;
  localparam logic [15:0] RISE_MAX_Q = 16'h007f;
  localparam logic [15:0] LIM_MAX_Q  = 16'h01fc;
  // linear format: value scale shift for quarter ms and for volts
  localparam int SH_QMS = 2;
  localparam int SH_VLT = 10;

  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_DELAY  = 3'b001,
    S_RAMP   = 3'b010,
    S_ON     = 3'b011,
    S_RESTART_INTERVAL = 3'b100,
    S_LATCH  = 3'b101
  } ttr_state_t;

  typedef struct packed {
    logic [15:0] vin_uv;
    logic [15:0] ton_dly;
    logic [15:0] ton_rse;
    logic [15:0] ton_lim;
    logic [7:0]  ton_rsp;
  } ttr_cfg_t;

  // linear value (5-bit exponent, 11-bit mantissa) scaled by 2**sh
  function automatic logic [31:0] ttr_lin(input logic [15:0] l,
                                          input int sh);
    int e;
    logic [31:0] m;
    e = int'($signed(l[15:11])) + sh;
    m = l[10] ? 32'h0 : {21'h0, l[10:0]};
    if (e > 20) return 32'hffffffff;
    if (e >= 0) return m << e;
    if (e < -11) return 32'h0;
    return m >> (-e);
  endfunction : ttr_lin

  function automatic logic [15:0] ttr_sat(input logic [31:0] v);
    return (v > 32'h0000ffff) ? 16'hffff : v[15:0];
  endfunction : ttr_sat
endpackage : ttr_pkg

// ===== core/ttr_tick.sv
// quarter millisecond tick generator with restart.
// assumes restart comes from logic on the same clock.
`timescale 1ns/1ns
module ttr_tick #(
  parameter int TICK_CYC = ttr_pkg::TICK_CYC
) (
  input  wire logic clk_in,
  input  wire logic rstn_in,
  input  wire logic restart_in,
  output logic      tick_out
);
  localparam int W = $clog2(TICK_CYC + 1);
  localparam logic [W-1:0] TOP = W'(TICK_CYC - 1);

  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;

  always_comb begin
    if (restart_in || cnt == '0) next_cnt = TOP;
    else next_cnt = cnt - W'(1);
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) cnt <= TOP;
    else cnt <= next_cnt;
  end

  // restart realigns so a timer started now sees a full first tick
  assign tick_out = (cnt == '0) && !restart_in;

  tick_period_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    tick_out |=> !tick_out)
    else $error("tick pulse longer than one cycle");
endmodule : ttr_tick

// ===== verif/ttr_stage_model.sv
// output stage model: reports output good some cycles after enable.
// assumes en_in comes from the sequencer on the same clock.
`timescale 1ns/1ns
module ttr_stage_model #(
  parameter int LAG = 3
) (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rstn_in,
  // stage control
  input  wire logic en_in,
  input  wire logic healthy_in,
  // feedback
  output logic      good_out
);
  int cnt;

  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) cnt <= 0;
    else if (!en_in) cnt <= 0;
    else if (cnt < LAG) cnt <= cnt + 1;
  end
  // a faulty stage never reaches target, so good stays low
  assign good_out = en_in && healthy_in && (cnt >= LAG);
endmodule : ttr_stage_model

// ===== verif/ttr_core_test.sv
// self-checking bench for the turn-on sequencer.
// assumes a short tick of T cycles; times are given in quarter ms ticks.
`timescale 1ns/1ns
module ttr_core_test;
  localparam int T = 4;
  logic        clk, rstn, start, clr, wr_en, good_en, vgood, p;
  logic        out_en, ramp, alert_n, ton_fault, uv_warn;
  logic [7:0]  code, rd_code;
  logic [15:0] data, vin, rd_data, got, thr;
  int          failures, checks_done, cycles, seed, n, m, k, c;
  int          dm[4];
  logic [7:0]  cmds[5];

  ttr_core #(.TICK_CYC(T)) dut (
    .CLK_IN(clk), .RSTN_IN(rstn), .START_IN(start), .VOUT_GOOD_IN(vgood),
    .VIN_MEAS_IN(vin), .CLR_FAULT_IN(clr), .CMD_WR_IN(wr_en),
    .CMD_CODE_IN(code), .CMD_DATA_IN(data), .CMD_RD_CODE_IN(rd_code),
    .RD_DATA_OUT(rd_data), .OUT_EN_OUT(out_en), .RAMP_OUT(ramp),
    .ALERT_N_OUT(alert_n), .TON_FAULT_OUT(ton_fault), .UV_WARN_OUT(uv_warn));
  ttr_stage_model #(.LAG(3)) model (
    .clk_in(clk), .rstn_in(rstn), .en_in(out_en), .healthy_in(good_en),
    .good_out(vgood));

  initial clk = 1'b0;
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      end_sim();
    end
  end

  task end_sim;
    if (failures == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  task chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task ok(input logic b);
    chk({15'h0, b}, 16'h0001);
  endtask : ok

  // linear value with exponent -2: mantissa counts quarter ms
  function automatic logic [15:0] lq(input int q);
    return {5'h1e, q[10:0]};
  endfunction : lq

  function automatic int clamp(input int r);
    return (r < 2) ? 2 : r;
  endfunction : clamp

  function automatic logic sig(input int w);
    case (w)
      0: return out_en;
      1: return ramp;
      default: return ton_fault;
    endcase
  endfunction : sig

  task wr(input logic [7:0] cd, input logic [15:0] dt);
    @(posedge clk);
    wr_en <= 1'b1;
    code <= cd;
    data <= dt;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] cd, output logic [15:0] g);
    @(posedge clk);
    rd_code <= cd;
    @(posedge clk);
    @(negedge clk);
    g = rd_data;
  endtask : rd

  task wait_for(input int w, input logic v, output int cnt);
    cnt = 0;
    while (sig(w) !== v && cnt < 3000) begin
      @(negedge clk);
      cnt++;
    end
    ok(cnt < 3000);
  endtask : wait_for

  task count_on(input int len, output int cnt);
    cnt = 0;
    p = out_en;
    repeat (len) begin
      @(negedge clk);
      if (out_en === 1'b1 && p !== 1'b1) cnt++;
      p = out_en;
    end
  endtask : count_on

  task go(input int d, r, l, input logic [7:0] rs, input logic h);
    wr(ttr_pkg::CMD_TON_DLY, lq(d));
    wr(ttr_pkg::CMD_TON_RSE, lq(r));
    wr(ttr_pkg::CMD_TON_LIM, lq(l));
    wr(ttr_pkg::CMD_TON_RSP, {8'h00, rs});
    @(posedge clk);
    start <= 1'b1;
    good_en <= h;
    @(negedge clk);
  endtask : go

  task off;
    @(posedge clk);
    start <= 1'b0;
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask : off

  initial begin
    seed = 32'hd293ce9f;
    {rstn, start, clr, wr_en, good_en} = 5'h0;
    {code, rd_code, data, vin} = '0;
    cmds = '{ttr_pkg::CMD_VIN_UV, ttr_pkg::CMD_TON_DLY, ttr_pkg::CMD_TON_RSE,
             ttr_pkg::CMD_TON_LIM, ttr_pkg::CMD_TON_RSP};
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    for (k = 0; k < 5; k++) begin
      rd(cmds[k], got);
      chk(got, 16'h0000);
      thr = 16'($random(seed));
      wr(cmds[k], thr);
      rd(cmds[k], got);
      chk(got, (k == 4) ? {8'h00, thr[7:0]} : thr);
    end
    wr(8'h5f, 16'hffff);
    rd(8'h5f, got);
    chk(got, 16'h0000);
    // undervoltage warning compare, equal is not below
    for (k = 0; k < 8; k++) begin
      thr = {6'h00, 10'($random(seed))};
      wr(ttr_pkg::CMD_VIN_UV, thr);
      vin <= 16'h03ff;
      off();
      @(posedge clk);
      vin <= (k == 0) ? thr : {6'h00, 10'($random(seed))};
      repeat (4) @(posedge clk);
      @(negedge clk);
      ok(uv_warn === (vin < thr));
      ok(alert_n === !(vin < thr));
    end
    wr(ttr_pkg::CMD_VIN_UV, 16'h0000);
    vin <= 16'h03ff;
    off();
    // turn-on delay, rise clamp, good turn-on
    for (k = 0; k < 6; k++) begin
      n = (k == 0) ? 0 : ($random(seed) & 15);
      m = (k < 5) ? k * 30 : (($random(seed) & 127) | 3);
      go(n, (k == 4) ? 127 : m, 0, 8'h00, 1'b1);
      wait_for(0, 1'b1, c);
      ok(c >= n * T + 2 && c <= n * T + 6);
      wait_for(1, 1'b0, c);
      n = clamp((k == 4) ? 127 : m) * T;
      ok(c >= n - 2 && c <= n + 2);
      repeat (40) @(negedge clk);
      ok(out_en === 1'b1 && ton_fault === 1'b0);
      off();
    end
    // stuck output with zero limit never times out
    go(0, 2, 0, 8'h80, 1'b0);
    repeat (300) @(negedge clk);
    ok(ton_fault === 1'b0 && alert_n === 1'b1 && out_en === 1'b1);
    off();
    // timeout moment, ignore response keeps running
    for (k = 2; k <= 6; k += 4) begin
      go(0, 40, k, 8'h00, 1'b0);
      wait_for(0, 1'b1, c);
      wait_for(2, 1'b1, c);
      ok(c >= k * T && c <= k * T + 4);
      ok(out_en === 1'b1 && alert_n === 1'b0);
      off();
    end
    // latch off: start is ignored until cleared
    go(0, 8, 2, 8'h80, 1'b0);
    count_on(400, c);
    chk(16'(c), 16'h0001);
    rd(ttr_pkg::CMD_SEQ_STS, got);
    chk({13'h0, got[6:4]}, 16'h0005);
    off();
    rd(ttr_pkg::CMD_SEQ_STS, got);
    chk({13'h0, got[6:4]}, 16'h0000);
    // limited retries, each episode with the full budget
    for (k = 1; k <= 6; k++) begin
      go(0, 8, 2, {((k & 1) ? 2'b10 : 2'b11), 3'(k), 3'h0}, 1'b0);
      count_on(900, c);
      chk(16'(c), 16'(k + 1));
      ok(out_en === 1'b0 && ton_fault === 1'b1);
      off();
    end
    go(0, 8, 2, 8'hb8, 1'b0);
    count_on(900, c);
    ok(c >= 15);
    off();
    ok(out_en === 1'b0);
    // restart interval scales with the delay code
    for (k = 0; k < 3; k++) begin
      go(0, 8, 2, 8'hb8 | 8'(k == 2 ? 3 : k), 1'b0);
      wait_for(0, 1'b0, c);
      wait_for(0, 1'b1, c);
      wait_for(0, 1'b0, c);
      wait_for(0, 1'b1, dm[k]);
      off();
    end
    chk(16'(dm[1] - dm[0]), 16'h0000);
    chk(16'(dm[2] - dm[1]), 16'(2 * 8 * T));
    // deferred shutdown length by delay code
    cmds = '{8'h0, 8'h1, 8'h2, 8'h5, 8'h0};
    for (k = 0; k < 4; k++) begin
      go(0, 40, 2, 8'h40 | cmds[k], 1'b0);
      wait_for(2, 1'b1, c);
      wait_for(0, 1'b0, dm[k]);
      ok(dm[k] <= 8);
      off();
    end
    chk(16'(dm[1] - dm[0]), 16'h0000);
    chk(16'(dm[2] - dm[1]), 16'h0002);
    chk(16'(dm[3] - dm[1]), 16'h0006);
    end_sim();
  end
endmodule : ttr_core_test
